// [rtl/hmm_exec.sv]
// execution unit: high-half moves, product register writes, multiplies
// assumes issue logic holds an instruction until issue_ready is seen
// What the document requires of this block and of software
// [RQ1] cop2 high-half move writes source word into bits 63..32 of selected register
// [RQ2] missing or narrow cop2 target gives an arbitrary result
// [RQ3] before release 2, high-half moves raise reserved-instruction
// [RQ4] software does fpr low-word move before high-half move
// [RQ5] software does cop2 low-word move before high-half move
// [RQ6] upper product write decoded by 000000, zero field, 0010110101, 111100
// [RQ7] lower product write decoded by 0011110101, 111100, zero field
// [RQ8] software reads a product result before writing product registers again
// [RQ9] upper write after multiply before read may corrupt lower
// [RQ10] lower write after multiply before read may corrupt upper
// [RQ11] multiply to register writes low 32 of signed product, no exception
// [RQ12] reading the multiply destination early stalls until ready
// [RQ13] float multiply rounds by control register mode, writes fd
// [RQ14] paired-single multiplies halves separately, ORs exception flags
// [RQ15] paired-single in 16-register mode gives arbitrary result
// [RQ16] float multiply signals inexact, unimpl, invalid, overflow, underflow
// [RQ17] product-pair multiply puts low word in lower, high in upper
// [RQ18] product reads during a pair multiply stall until both written
module hmm_exec (
  input wire logic clk,
  input wire logic rst_n,
  input hmm_pkg::hmm_issue_t issue,
  input wire logic [3:0] arch_release,
  input wire logic fr_16_mode,
  input wire logic cop1_usable,
  input wire logic cop2_usable,
  input wire logic [1:0] round_mode,
  input wire logic gpr_rd_valid,
  input wire logic [4:0] gpr_rd_idx,
  input wire logic prod_rd,
  output logic issue_ready,
  output logic stall,
  output logic gpr_we,
  output logic [4:0] gpr_widx,
  output logic [31:0] gpr_wdata,
  output logic fpr_we,
  output logic [4:0] fpr_widx,
  output logic [63:0] fpr_wdata,
  output logic fpr_hi_only,
  output logic cp2_we,
  output logic [4:0] cp2_widx,
  output logic [31:0] cp2_wdata_hi,
  output logic [31:0] upper_q,
  output logic [31:0] lower_q,
  output logic ri_exc,
  output logic cpu_exc,
  output hmm_pkg::hmm_fpx_t fpx
);
  import hmm_pkg::*;

  typedef enum logic [1:0] {
    HMM_IDLE = 2'b00, HMM_BUSY = 2'b01, HMM_DONE = 2'b11
  } hmm_state_t;

  hmm_state_t st_q, st_d;
  logic [3:0] cnt_q;
  logic pair_q;
  logic [4:0] mdst_q;
  logic [63:0] prod_q;
  logic [31:0] ylo, yhi;
  hmm_fpx_t fxlo, fxhi;
  logic is_uw, is_lw, is_pm, hi_move, ri_d, cu_d, busy, rd_hazard;
  logic take;

  always_comb begin
    is_uw = is_pool(issue.instr, MIN_UPPER_WR) &&
            issue.instr[25:RT_LSB] == 5'h00; // RQ6
    is_lw = is_pool(issue.instr, MIN_LOWER_WR) &&
            issue.instr[25:RT_LSB] == 5'h00; // RQ7
    is_pm = is_pool(issue.instr, MIN_PAIR_MUL); // RQ17
    hi_move = issue.op == HMM_OP_FHM || issue.op == HMM_OP_CHM;
    ri_d = hi_move && arch_release < 4'(MIN_ARCH_REL); // RQ3
    ri_d = ri_d || (issue.op == HMM_OP_FMUL && issue.fmt == HMM_FMT_PS &&
                    fr_16_mode); // RQ15
    cu_d = ((issue.op == HMM_OP_FHM || issue.op == HMM_OP_FMUL) &&
            !cop1_usable) || (issue.op == HMM_OP_CHM && !cop2_usable); // RQ16
  end

  assign busy = st_q == HMM_BUSY;
  // multiply unit is single-issue; new multiplies or product writes wait
  assign rd_hazard = busy && ((pair_q && prod_rd) ||
                     (!pair_q && gpr_rd_valid && gpr_rd_idx == mdst_q));
  // ready mirrors idle, and the issue side lets go on ready, so taking only
  // in idle keeps the two in step; a take in done would be lost otherwise
  assign take = issue.valid && st_q == HMM_IDLE;

  // one product for both multiplies; low 32 only for the register form
  function automatic logic [63:0] smul(input logic [31:0] a,
                                       input logic [31:0] b);
    return $signed(a) * $signed(b);
  endfunction

  always_comb begin
    st_d = st_q;
    case (st_q)
      HMM_IDLE: if (take && (is_pm || issue.op == HMM_OP_MUL_RD)) begin
        st_d = HMM_BUSY;
      end
      HMM_BUSY: if (cnt_q == 4'd1) begin
        st_d = HMM_DONE;
      end
      HMM_DONE: st_d = HMM_IDLE;
      default: st_d = HMM_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= HMM_IDLE;
      cnt_q <= 4'h0;
      pair_q <= 1'b0;
      mdst_q <= 5'h00;
      prod_q <= 64'h0;
    end else begin
      st_q <= st_d;
      if (st_q == HMM_IDLE && st_d == HMM_BUSY) begin
        cnt_q <= MUL_CYC;
        pair_q <= is_pm;
        mdst_q <= issue.dst;
        prod_q <= smul(issue.rs_val, issue.rt_val); // RQ11 RQ17
      end else if (busy) begin
        cnt_q <= cnt_q - 4'd1;
      end
    end
  end

  // direct writes only touch their own half; the other keeps its value,
  // which is one legal reading of the unpredictable case
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      upper_q <= PROD_RST;
      lower_q <= PROD_RST;
    end else if (st_q == HMM_DONE && pair_q) begin
      upper_q <= prod_q[63:HIGH_LSB]; // RQ17
      lower_q <= prod_q[31:0];
    end else if (take && st_q == HMM_IDLE) begin
      if (is_uw) begin
        upper_q <= issue.rs_val; // RQ6 RQ9
      end
      if (is_lw) begin
        lower_q <= issue.rs_val; // RQ7 RQ10
      end
    end
  end

  hmm_fmul u_lo (
    .a(issue.fs_val[31:0]),
    .b(issue.ft_val[31:0]),
    .rmode(round_mode),
    .y(ylo),
    .fx(fxlo)
  );
  hmm_fmul u_hi (
    .a(issue.fs_val[63:32]),
    .b(issue.ft_val[63:32]),
    .rmode(round_mode),
    .y(yhi),
    .fx(fxhi)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      issue_ready <= 1'b1;
      stall <= 1'b0;
      gpr_we <= 1'b0;
      gpr_widx <= 5'h00;
      gpr_wdata <= 32'h0;
      fpr_we <= 1'b0;
      fpr_widx <= 5'h00;
      fpr_wdata <= 64'h0;
      fpr_hi_only <= 1'b0;
      cp2_we <= 1'b0;
      cp2_widx <= 5'h00;
      cp2_wdata_hi <= 32'h0;
      ri_exc <= 1'b0;
      cpu_exc <= 1'b0;
      fpx <= '0;
    end else begin
      issue_ready <= st_d == HMM_IDLE;
      stall <= rd_hazard; // RQ12 RQ18
      gpr_we <= st_q == HMM_DONE && !pair_q; // RQ11
      gpr_widx <= mdst_q;
      gpr_wdata <= prod_q[31:0];
      ri_exc <= take && ri_d;
      cpu_exc <= take && cu_d;
      fpr_we <= 1'b0;
      cp2_we <= 1'b0;
      fpx <= '0;
      if (take && !ri_d && !cu_d) begin
        case (issue.op)
          HMM_OP_FHM: begin
            fpr_we <= 1'b1;
            fpr_widx <= issue.dst;
            fpr_hi_only <= 1'b1;
            fpr_wdata <= {issue.rt_val, 32'h0};
          end
          HMM_OP_CHM: begin
            // selector passed through untouched; cop2 decides its meaning
            cp2_we <= 1'b1; // RQ1 RQ2
            cp2_widx <= issue.dst;
            cp2_wdata_hi <= issue.rt_val;
          end
          HMM_OP_FMUL: begin
            fpr_we <= 1'b1; // RQ13
            fpr_widx <= issue.dst;
            fpr_hi_only <= 1'b0;
            if (issue.fmt == HMM_FMT_PS) begin
              fpr_wdata <= {yhi, ylo}; // RQ14
              fpx <= fxlo | fxhi; // RQ14 RQ16
            end else begin
              // double handled as unimplemented: no wide multiplier here
              fpr_wdata <= {32'h0, ylo};
              fpx <= issue.fmt == HMM_FMT_D ? hmm_fpx_t'(5'b01000) : fxlo;
            end
          end
          default: ;
        endcase
      end
    end
  end

  a_pair_lands: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == HMM_DONE && pair_q |=> upper_q == $past(prod_q[63:32]) &&
    lower_q == $past(prod_q[31:0])) // RQ17
    else $error("pair multiply result not in product registers");
  a_upper_write: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == HMM_IDLE && issue.valid && is_uw |=>
    upper_q == $past(issue.rs_val)) // RQ6
    else $error("upper product write lost");
  a_lower_write: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == HMM_IDLE && issue.valid && is_lw |=>
    lower_q == $past(issue.rs_val)) // RQ7
    else $error("lower product write lost");
  a_old_release: assert property (@(posedge clk) disable iff (!rst_n)
    issue.valid && hi_move && arch_release < 4'd2 && st_q == HMM_IDLE
    |=> ri_exc && !fpr_we && !cp2_we) // RQ3
    else $error("high-half move not refused before release 2");
  a_cop2_high: assert property (@(posedge clk) disable iff (!rst_n)
    cp2_we |-> cp2_wdata_hi == $past(issue.rt_val)) // RQ1
    else $error("cop2 high half wrong");
  // start edge to the edge that samples the writeback pulse
  localparam int MUL_LAT = int'(MUL_CYC) + 2;
  // low word of a product is the same signed or unsigned
  a_mul_rd: assert property (@(posedge clk) disable iff (!rst_n)
    st_q == HMM_IDLE && st_d == HMM_BUSY && !is_pm |->
    ##[1:8] gpr_we ##0 gpr_wdata ==
    32'($past(issue.rs_val, MUL_LAT) * $past(issue.rt_val, MUL_LAT)))
    // RQ11
    else $error("multiply to register result wrong or late");
  sequence s_pair_start;
    st_q == HMM_IDLE && st_d == HMM_BUSY && is_pm;
  endsequence
  sequence s_pair_run;
    busy [*3] ##1 st_q == HMM_DONE ##1 st_q == HMM_IDLE && issue_ready;
  endsequence
  a_pair_timing: assert property (@(posedge clk) disable iff (!rst_n)
    s_pair_start |=> s_pair_run) // RQ18
    else $error("pair multiply timing wrong");
  a_ready_busy: assert property (@(posedge clk) disable iff (!rst_n)
    busy |-> !issue_ready) // RQ12
    else $error("ready shown while multiply busy");
  a_stall_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !busy |=> !stall) // RQ12
    else $error("stall without a running multiply");
  a_idle_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    !take |=> !fpr_we && !cp2_we && !ri_exc && !cpu_exc) // RQ13
    else $error("write or exception without a taken instruction");
  a_cu_refuse: assert property (@(posedge clk) disable iff (!rst_n)
    take && issue.op == HMM_OP_FMUL && !cop1_usable |=>
    cpu_exc && !fpr_we) // RQ16
    else $error("float multiply ran with coprocessor unusable");
  a_ps16_refuse: assert property (@(posedge clk) disable iff (!rst_n)
    take && issue.op == HMM_OP_FMUL && issue.fmt == HMM_FMT_PS &&
    fr_16_mode |=> ri_exc && !fpr_we) // RQ15
    else $error("paired multiply ran in 16-register mode");
  a_fhm_high: assert property (@(posedge clk) disable iff (!rst_n)
    fpr_we && fpr_hi_only |-> fpr_wdata[63:32] == $past(issue.rt_val))
    // RQ1
    else $error("fpr high half wrong");
  a_read_stall: assert property (@(posedge clk) disable iff (!rst_n)
    busy && pair_q && prod_rd |=> stall) // RQ18
    else $error("product read not stalled");
  a_gpr_stall: assert property (@(posedge clk) disable iff (!rst_n)
    busy && !pair_q && gpr_rd_valid && gpr_rd_idx == mdst_q |=> stall)
    // RQ12
    else $error("destination read not stalled");
  a_ps_flags: assert property (@(posedge clk) disable iff (!rst_n)
    take && !ri_d && !cu_d && issue.op == HMM_OP_FMUL &&
    issue.fmt == HMM_FMT_PS |=> fpx == ($past(fxlo) | $past(fxhi))) // RQ14
    else $error("paired flags not merged");
endmodule

// [rtl/hmm_pkg.sv]
// package for the product-register / multiply execution datapath
// assumes one core clock; shared by the exec unit and the fp multiplier
package hmm_pkg;
  localparam logic [5:0] MAJOR_INT = 6'h00;
  localparam logic [5:0] POOL_XF = 6'h3C;
  localparam logic [9:0] MIN_UPPER_WR = 10'h0B5;
  localparam logic [9:0] MIN_LOWER_WR = 10'h0F5;
  localparam logic [9:0] MIN_PAIR_MUL = 10'h22C;
  localparam int OPC_LSB = 26;
  localparam int RT_LSB = 21;
  localparam int RS_LSB = 16;
  localparam int MIN_LSB = 6;
  localparam int HIGH_LSB = 32;
  localparam int MIN_ARCH_REL = 2;
  localparam int MUL_NS = 15;
  localparam int CLK_PS = 5000;
  localparam logic [3:0] MUL_CYC = 4'((MUL_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [31:0] PROD_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    HMM_OP_NONE, HMM_OP_FHM, HMM_OP_CHM, HMM_OP_MUL_RD, HMM_OP_FMUL
  } hmm_op_t;
  typedef enum logic [1:0] {HMM_FMT_S, HMM_FMT_D, HMM_FMT_PS} hmm_fmt_t;

  typedef struct packed {
    logic valid;
    logic [31:0] instr;
    hmm_op_t op;
    hmm_fmt_t fmt;
    logic [4:0] dst;
    logic [31:0] rs_val;
    logic [31:0] rt_val;
    logic [63:0] fs_val;
    logic [63:0] ft_val;
  } hmm_issue_t;

  typedef struct packed {
    logic inexact;
    logic unimpl;
    logic invalid;
    logic overflow;
    logic underflow;
  } hmm_fpx_t;

  function automatic logic is_pool(input logic [31:0] w, input logic [9:0] m);
    return w[31:OPC_LSB] == MAJOR_INT && w[5:0] == POOL_XF &&
           w[15:MIN_LSB] == m;
  endfunction
endpackage

// [rtl/hmm_fmul.sv]
// single-precision multiply lane, rounding to nearest, toward zero, +inf or -inf
// assumes normal operands; subnormals flagged unimplemented
module hmm_fmul (
  input wire logic [31:0] a,
  input wire logic [31:0] b,
  input wire logic [1:0] rmode,
  output logic [31:0] y,
  output hmm_pkg::hmm_fpx_t fx
);
  import hmm_pkg::*;
  logic [47:0] m;
  logic [9:0] e;
  logic [23:0] mant;
  logic grd, sticky, rnd, sgn;
  logic [24:0] mr;
  always_comb begin
    sgn = a[31] ^ b[31];
    m = {1'b1, a[22:0]} * {1'b1, b[22:0]};
    e = 10'({2'b00, a[30:23]}) + 10'({2'b00, b[30:23]}) - 10'd127;
    if (m[47]) begin
      mant = m[47:24];
      grd = m[23];
      sticky = |m[22:0];
      e = e + 10'd1;
    end else begin
      mant = m[46:23];
      grd = m[22];
      sticky = |m[21:0];
    end
    // rounding modes: 0 nearest, 1 zero, 2 +inf, 3 -inf
    case (rmode)
      2'd0: rnd = grd & (sticky | mant[0]);
      2'd2: rnd = ~sgn & (grd | sticky);
      2'd3: rnd = sgn & (grd | sticky);
      default: rnd = 1'b0;
    endcase
    mr = {1'b0, mant} + 25'(rnd);
    if (mr[24]) e = e + 10'd1;
    fx = '0;
    fx.inexact = grd | sticky;
    fx.unimpl = (a[30:23] == 8'h00 && a[22:0] != 0) ||
                (b[30:23] == 8'h00 && b[22:0] != 0);
    fx.invalid = (&a[30:23] && a[22:0] != 0) || (&b[30:23] && b[22:0] != 0);
    y = {sgn, e[7:0], mr[24] ? mr[23:1] : mr[22:0]};
    if (a[30:0] == 0 || b[30:0] == 0) begin
      y = {sgn, 31'h0};
      fx.inexact = 1'b0;
    end else if (!e[9] && e[8:0] >= 9'd255) begin
      fx.overflow = 1'b1;
      y = {sgn, 8'hFF, 23'h0};
    end else if (e[9] || e[7:0] == 8'h00) begin
      fx.underflow = 1'b1;
      y = {sgn, 31'h0};
    end
  end
endmodule

// [bench/hmm_issue_model.sv]
// issue-side model: holds one instruction until the exec unit takes it
// assumes the bench loads req and pulses send while nothing is pending
module hmm_issue_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic issue_ready,
  input wire logic send,
  input hmm_pkg::hmm_issue_t req,
  output hmm_pkg::hmm_issue_t issue
);
  import hmm_pkg::*;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      issue <= '0;
    end else if (send) begin
      issue <= req;
      issue.valid <= 1'b1;
    end else if (issue.valid && issue_ready) begin
      // scrambled once taken so stale operands cannot pass
      issue <= ~issue;
      issue.valid <= 1'b0;
    end
  end
endmodule

// [bench/test_hilo_multiply_move_exec.sv]
// self-checking bench for the product and multiply execution unit
// assumes the exec unit takes requests while issue_ready is high
module test_hilo_multiply_move_exec;
  timeunit 1ns;
  timeprecision 1ps;
  import hmm_pkg::*;
  logic clk, rst_n, send, issue_ready, stall, gpr_we, fpr_we, fpr_hi_only;
  logic cp2_we, ri_exc, cpu_exc, fr_16_mode, cop1_usable, cop2_usable;
  logic gpr_rd_valid, prod_rd, s_gpr, s_fpr, s_cp2, s_ri, s_cpu, s_stall;
  logic [3:0] arch_release;
  logic [1:0] round_mode;
  logic [4:0] gpr_rd_idx, gpr_widx, fpr_widx, cp2_widx, c_gi, c_ci;
  logic [31:0] gpr_wdata, cp2_wdata_hi, upper_q, lower_q, c_g, c_c;
  logic [63:0] fpr_wdata, c_f;
  logic [31:0] rexp [4] = '{32'h3F800002, 32'h3F800002, 32'h3F800003,
                           32'h3F800002};
  hmm_fpx_t fpx, c_fx;
  hmm_issue_t req, issue;
  int fail_count, n_tests;

  hmm_issue_model model (.clk(clk), .rst_n(rst_n), .issue_ready(issue_ready),
    .send(send), .req(req), .issue(issue));
  hmm_exec uut (.clk(clk), .rst_n(rst_n), .issue(issue),
    .arch_release(arch_release), .fr_16_mode(fr_16_mode),
    .cop1_usable(cop1_usable), .cop2_usable(cop2_usable),
    .round_mode(round_mode), .gpr_rd_valid(gpr_rd_valid),
    .gpr_rd_idx(gpr_rd_idx), .prod_rd(prod_rd), .issue_ready(issue_ready),
    .stall(stall), .gpr_we(gpr_we), .gpr_widx(gpr_widx),
    .gpr_wdata(gpr_wdata), .fpr_we(fpr_we), .fpr_widx(fpr_widx),
    .fpr_wdata(fpr_wdata), .fpr_hi_only(fpr_hi_only), .cp2_we(cp2_we),
    .cp2_widx(cp2_widx), .cp2_wdata_hi(cp2_wdata_hi), .upper_q(upper_q),
    .lower_q(lower_q), .ri_exc(ri_exc), .cpu_exc(cpu_exc), .fpx(fpx));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // pulses last one cycle, so they are caught sticky mid-cycle
  always @(negedge clk) begin
    if (gpr_we) begin
      s_gpr = 1'b1;
      c_g = gpr_wdata;
      c_gi = gpr_widx;
    end
    if (fpr_we) begin
      s_fpr = 1'b1;
      c_f = fpr_wdata;
    end
    if (cp2_we) begin
      s_cp2 = 1'b1;
      c_c = cp2_wdata_hi;
      c_ci = cp2_widx;
    end
    s_ri = s_ri | ri_exc;
    s_cpu = s_cpu | cpu_exc;
    s_stall = s_stall | stall;
    c_fx = c_fx | fpx;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] pw(input logic [9:0] m,
                                     input logic [4:0] z, r);
    return {MAJOR_INT, z, r, m, POOL_XF};
  endfunction

  // issue one instruction, then wait until the unit is idle again
  task automatic run(input hmm_op_t op, input hmm_fmt_t fmt,
    input logic [4:0] d, input logic [31:0] ins, rs, rt,
    input logic [63:0] fs, ft);
    {s_gpr, s_fpr, s_cp2, s_ri, s_cpu, s_stall} = '0;
    c_fx = '0;
    req = '{1'b1, ins, op, fmt, d, rs, rt, fs, ft};
    @(posedge clk) send <= 1'b1;
    @(posedge clk) send <= 1'b0;
    repeat (20) begin
      @(negedge clk);
      if (issue_ready && !issue.valid) break;
    end
    repeat (3) @(negedge clk);
  endtask

  task automatic t_moves();
    run(HMM_OP_CHM, HMM_FMT_S, 5'h07, '0, '0, 32'hA5A5_1234, '0, '0);
    chk({s_cp2, c_ci, c_c, s_ri}, {1'b1, 5'h07, 32'hA5A5_1234, 1'b0});
    run(HMM_OP_FHM, HMM_FMT_S, 5'h03, '0, '0, 32'h0BAD_F00D, '0, '0);
    chk({s_fpr, c_f[63:32], fpr_hi_only, fpr_widx, s_ri},
        {1'b1, 32'h0BAD_F00D, 1'b1, 5'h03, 1'b0});
    @(posedge clk) arch_release <= 4'h1;
    run(HMM_OP_CHM, HMM_FMT_S, 5'h07, '0, '0, 32'h1, '0, '0);
    chk({s_cp2, s_ri}, 2'b01);
    run(HMM_OP_FHM, HMM_FMT_S, 5'h03, '0, '0, 32'h1, '0, '0);
    chk({s_fpr, s_ri}, 2'b01);
    @(posedge clk) arch_release <= 4'h2;
  endtask

  task automatic t_product();
    @(posedge clk) prod_rd <= 1'b1;
    run(HMM_OP_NONE, HMM_FMT_S, '0, pw(MIN_PAIR_MUL, 5'h02, 5'h04),
        32'h8000_0000, 32'h7FFF_FFFF, '0, '0);
    chk({upper_q, lower_q}, 64'hC000_0000_8000_0000);
    chk({s_stall, stall}, 2'b10);
    // the result was read before the direct writes below
    @(posedge clk) prod_rd <= 1'b0;
    run(HMM_OP_NONE, HMM_FMT_S, '0, pw(MIN_UPPER_WR, 5'h00, 5'h06),
        32'h1357_9BDF, '0, '0, '0);
    chk({upper_q, lower_q}, 64'h1357_9BDF_8000_0000);
    run(HMM_OP_NONE, HMM_FMT_S, '0, pw(MIN_LOWER_WR, 5'h00, 5'h06),
        32'h2468_ACE0, '0, '0, '0);
    chk({upper_q, lower_q}, 64'h1357_9BDF_2468_ACE0);
    run(HMM_OP_NONE, HMM_FMT_S, '0, pw(MIN_UPPER_WR, 5'h01, 5'h06),
        32'hFFFF_0000, '0, '0, '0);
    chk(upper_q, 32'h1357_9BDF);
  endtask

  task automatic t_mulrd();
    @(posedge clk) gpr_rd_valid <= 1'b1;
    run(HMM_OP_MUL_RD, HMM_FMT_S, 5'h09, '0, 32'hFFFF_FFFF,
        32'h1234_5678, '0, '0);
    chk({s_gpr, c_gi, c_g, s_ri}, {1'b1, 5'h09, 32'hEDCB_A988, 1'b0});
    chk(s_stall, 1'b1);
    @(posedge clk) gpr_rd_valid <= 1'b0;
  endtask

  task automatic t_fmul();
    run(HMM_OP_FMUL, HMM_FMT_S, 5'h02, '0, '0, '0, 64'h4000_0000,
        64'h4040_0000);
    chk({s_fpr, c_f[31:0], c_fx}, {1'b1, 32'h40C0_0000, 5'h00});
    for (int m = 0; m < 4; m++) begin
      @(posedge clk) round_mode <= 2'(m);
      run(HMM_OP_FMUL, HMM_FMT_S, 5'h02, '0, '0, '0, 64'h3F80_0001,
          64'h3F80_0001);
      chk({c_f[31:0], c_fx.inexact}, {rexp[m], 1'b1});
    end
    run(HMM_OP_FMUL, HMM_FMT_S, 5'h02, '0, '0, '0, 64'h7F00_0000,
        64'h7F00_0000);
    chk(c_fx.overflow, 1'b1);
    run(HMM_OP_FMUL, HMM_FMT_PS, 5'h04, '0, '0, '0,
        64'h4000_0000_3FC0_0000, 64'h4040_0000_7F80_0001);
    chk({c_f[63:32], c_fx.invalid}, {32'h40C0_0000, 1'b1});
    run(HMM_OP_FMUL, HMM_FMT_D, 5'h02, '0, '0, '0, 64'h4000_0000,
        64'h4040_0000);
    chk({s_fpr, c_fx}, {1'b1, 5'b01000});
    @(posedge clk) fr_16_mode <= 1'b1;
    run(HMM_OP_FMUL, HMM_FMT_PS, 5'h04, '0, '0, '0, '0, '0);
    chk({s_fpr, s_ri}, 2'b01);
    @(posedge clk) fr_16_mode <= 1'b0;
    cop1_usable <= 1'b0;
    run(HMM_OP_FMUL, HMM_FMT_S, 5'h02, '0, '0, '0, '0, '0);
    chk({s_fpr, s_cpu}, 2'b01);
  endtask

  initial begin
    {rst_n, send, fr_16_mode, gpr_rd_valid, prod_rd, round_mode} = '0;
    {cop1_usable, cop2_usable, arch_release, gpr_rd_idx} = {6'h32, 5'h09};
    req = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({issue_ready, gpr_we, fpr_we, cp2_we, ri_exc, cpu_exc}, 6'h20);
    chk({upper_q, lower_q}, {PROD_RST, PROD_RST});
    t_moves();
    t_product();
    t_mulrd();
    t_fmul();
    finish_test();
  end

  initial begin
    #20000;
    fail_count++;
    finish_test();
  end
endmodule
